// ==== cpu_sw_model.sv ====
// CPU software model: APB master that reads queued stamps and frees identifiers.
// Assumes an APB slave on the same clock; every wait on ready is bounded.
`timescale 1ns/1ps
`include "stamp_queue_consts.svh"
module cpu_sw_model (
   input  wire logic        CLK,     // Core clock
   output logic             PSEL,    // Slave select
   output logic             PENABLE, // Access phase
   output logic             PWRITE,  // Write direction
   output logic [11:0]      PADDR,   // Byte address
   output logic [31:0]      PWDATA,  // Write data
   input  wire logic [31:0] PRDATA,  // Read data
   input  wire logic        PREADY,  // Slave ready
   input  wire logic        PSLVERR  // Slave error
);
   // Idle bus at time zero
   initial begin
      PSEL    = 1'b0;
      PENABLE = 1'b0;
      PWRITE  = 1'b0;
      PADDR   = 12'h000;
      PWDATA  = 32'h0;
   end

   // One transfer: setup, access held until ready is seen at a rising edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e, output logic ok);
      int n;
      @(posedge CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 64);
      r = PRDATA;
      e = PSLVERR;
      ok = (PREADY === 1'b1);
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
      PWDATA  <= ~d; // Released data shows no stale value
   endtask

   // Free one identifier through the register that holds its bit
   task automatic release_id(input logic [5:0] id, output logic ok);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, id[5] ? `OFS_REL_UPPER : `OFS_REL_LOWER, 32'h1 << id[4:0], r, e, ok);
   endtask
endmodule // cpu_sw_model

// ==== stamp_queue_consts.svh ====
// Constants for the two-step transmit time stamp queue.
// Included by the package and the design file; definitions only.
`ifndef STAMP_QUEUE_CONSTS_SVH
`define STAMP_QUEUE_CONSTS_SVH
`define SQ_DEPTH         128
`define SQ_PTR_W         7
`define SQ_CNT_W         8
`define SQ_STAMP_W       32
`define SQ_ID_W          6
`define SQ_PORT_W        4
`define SQ_NPORTS        11
`define SQ_ACT_W         3
`define SQ_ACT_TWO_STEP  3'h3
`define SQ_ID_UNTRUSTED  6'h3f
`define SQ_ID_FIRST_FREE 6'h04
`define SQ_ID_POOL_INIT  64'h000000000000000f
`define SQ_ID_LO_ALLOC   4
`define SQ_ID_HI_ALLOC   62
`define SQ_FREE_IDS      7'd59
`define OFS_HEAD_VALUE   12'h000
`define OFS_ADVANCE      12'h004
`define OFS_HEAD_STATUS  12'h008
`define OFS_REL_UPPER    12'h00c
`define OFS_REL_LOWER    12'h010
`define OFS_TWO_STEP_DIS 12'h014
`define OFS_FREE_COUNT   12'h018
`define ST_VALID_BIT     0
`define ST_ID_LSB        1
`define ST_PORT_LSB      7
`define ST_OAM_BIT       11
`define ST_OVFL_BIT      12
`endif

// ==== stamp_queue_pkg.sv ====
// Types for the two-step transmit time stamp queue.
// Assumes the constants header sits in the same folder.
`include "stamp_queue_consts.svh"
package stamp_queue_pkg;
   typedef struct packed {
      logic                      oam;
      logic [`SQ_PORT_W-1:0]     port;
      logic [`SQ_ID_W-1:0]       id;
      logic [`SQ_STAMP_W-1:0]    stamp;
   } stamp_entry_t;
   typedef enum logic [1:0] {
      ALLOC_IDLE = 2'b01,
      ALLOC_HELD = 2'b10
   } alloc_state_t;
endpackage

// ==== two_step_timestamp_queue.sv ====
// Two-step transmit time stamp queue with frame identifier pool and APB slave.
// Assumes one clock, egress stamps synchronous to CLK, APB master in same domain.
//
// Overview of operation
// - Rewrite action 3 records stamp, frame untouched
// - One shared queue of 128 entries
// - Each entry has a ready valid bit
// - Six-bit identifier, unique per stamped frame
// - Identifier replaces DSCP in extraction header
// - No free identifier gives value 63
// - Multiport frame: one entry per port
// - OAM flag zero for two-step entries
// - Full queue drops stamp, sets overflow
// - Head entry readable through status and value
// - Advance write pops the head entry
// - CPU-bound frames create no queue entry
// - CPU-bound frames carry Rx stamp instead
// - Allocate free identifiers, 63 only when exhausted
// - Identifiers 0 to 3 never allocated
// - Release bits return identifiers to pool
// - Per-port disable overrides classifier action
// - Stamp taken at first byte to PHY
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "stamp_queue_consts.svh"
module two_step_timestamp_queue
   import stamp_queue_pkg::*;
(
   input  wire logic                   CLK,          // Core clock, 40 MHz
   input  wire logic                   RST,          // Async reset, active high
   // APB slave
   input  wire logic                   PSEL,         // Slave select
   input  wire logic                   PENABLE,      // Access phase
   input  wire logic                   PWRITE,       // Write direction
   input  wire logic [11:0]            PADDR,        // Byte address
   input  wire logic [31:0]            PWDATA,       // Write data
   output logic      [31:0]            PRDATA,       // Read data
   output logic                        PREADY,       // Always ready
   output logic                        PSLVERR,      // Unmapped access
   // Analyzer: identifier request per classified frame
   input  wire logic                   ALLOC_REQ,    // Frame classified, pulse
   input  wire logic [`SQ_ACT_W-1:0]   ALLOC_ACTION, // Rewrite action code
   input  wire logic                   ALLOC_TO_CPU, // Frame bound for extraction
   input  wire logic [47:0]            ALLOC_RX_STAMP, // Rx stamp of frame
   output logic                        ALLOC_TWO_STEP, // Frame needs Tx stamps
   output logic [`SQ_ID_W-1:0]         ALLOC_ID,     // Assigned identifier
   output logic [5:0]                  XTR_DSCP,     // Extraction header DSCP field
   output logic [47:0]                 XTR_RX_STAMP, // Extraction header Rx stamp
   output logic                        XTR_VALID,    // Header fields valid
   // Egress: stamp at first byte toward PHY
   input  wire logic                   TX_STAMP_VLD, // Stamp event, pulse
   input  wire logic [`SQ_STAMP_W-1:0] TX_STAMP,     // Tx time
   input  wire logic [`SQ_PORT_W-1:0]  TX_PORT,      // Egress port
   input  wire logic [`SQ_ID_W-1:0]    TX_ID,        // Frame identifier
   input  wire logic                   TX_TWO_STEP,  // Frame carries two-step mark
   input  wire logic                   TX_TO_CPU     // Frame bound for extraction
);

   // Queue storage and pointers
   stamp_entry_t               mem_q [`SQ_DEPTH];
   logic [`SQ_PTR_W-1:0]       wr_ptr_q;
   logic [`SQ_PTR_W-1:0]       rd_ptr_q;
   logic [`SQ_CNT_W-1:0]       count_q;
   logic                       ovfl_q;
   logic [63:0]                used_q;
   logic [`SQ_NPORTS-1:0]      dis_q;
   logic [`SQ_ID_W-1:0]        alloc_id_q;
   logic                       alloc_two_q;
   logic [5:0]                 xtr_dscp_q;
   logic [47:0]                xtr_rx_q;
   logic                       xtr_vld_q;
   logic [31:0]                prdata_q;
   logic                       pslverr_q;
   alloc_state_t               alloc_st_q;

   // Bus decode
   wire        acc      = PSEL & PENABLE;
   wire        wr       = acc & PWRITE;
   wire        rd       = acc & ~PWRITE;
   wire        hit_val  = PADDR == `OFS_HEAD_VALUE;
   wire        hit_adv  = PADDR == `OFS_ADVANCE;
   wire        hit_st   = PADDR == `OFS_HEAD_STATUS;
   wire        hit_up   = PADDR == `OFS_REL_UPPER;
   wire        hit_lo   = PADDR == `OFS_REL_LOWER;
   wire        hit_dis  = PADDR == `OFS_TWO_STEP_DIS;
   wire        hit_cnt  = PADDR == `OFS_FREE_COUNT;
   wire        mapped   = hit_val | hit_adv | hit_st | hit_up | hit_lo | hit_dis | hit_cnt;

   // Queue status
   wire        empty    = count_q == '0;
   wire        full     = count_q == `SQ_CNT_W'(`SQ_DEPTH);
   wire        port_ok  = TX_PORT < `SQ_PORT_W'(`SQ_NPORTS);
   wire        port_dis = port_ok ? dis_q[TX_PORT] : 1'b0;
   wire        want     = TX_STAMP_VLD & TX_TWO_STEP & ~TX_TO_CPU & ~port_dis;
   wire        push     = want & ~full;
   wire        pop      = wr & hit_adv & ~empty;
   wire        drop     = want & full;
   stamp_entry_t head;
   stamp_entry_t new_ent;
   assign head    = mem_q[rd_ptr_q];
   assign new_ent = '{oam: 1'b0, port: TX_PORT, id: TX_ID, stamp: TX_STAMP};

   // Identifier allocation: lowest free id at or above 4, else 63
   logic [`SQ_ID_W-1:0] free_id;
   logic                free_found;
   always_comb begin
      free_id    = `SQ_ID_UNTRUSTED;
      free_found = 1'b0;
      for (int i = `SQ_ID_HI_ALLOC; i >= `SQ_ID_LO_ALLOC; i--) begin
         if (!used_q[i]) begin
            free_id    = `SQ_ID_W'(i);
            free_found = 1'b1;
         end
      end
   end
   wire        two_step_frm = ALLOC_REQ & (ALLOC_ACTION == `SQ_ACT_TWO_STEP);
   // Refused requests in the held cycle must not claim an identifier
   wire        grant        = two_step_frm & free_found & (alloc_st_q == ALLOC_IDLE);
   wire [63:0] rel_mask     = (wr & hit_up) ? {PWDATA, 32'h0} :
                              (wr & hit_lo) ? {32'h0, PWDATA} : 64'h0;
   wire [63:0] set_mask     = grant ? (64'h1 << free_id) : 64'h0;

   // Free count for software, reserved ids excluded
   logic [6:0] used_cnt;
   always_comb begin
      used_cnt = 7'h00;
      for (int i = `SQ_ID_LO_ALLOC; i <= `SQ_ID_HI_ALLOC; i++) begin
         used_cnt = used_cnt + 7'(used_q[i]);
      end
   end

   // Status word of head entry; valid reads zero when empty
   wire [31:0] status_w = ({31'h0, ~empty} << `ST_VALID_BIT)
                        | (32'(empty ? 6'h00 : head.id) << `ST_ID_LSB)
                        | (32'(empty ? 4'h0 : head.port) << `ST_PORT_LSB)
                        | (32'(empty ? 1'b0 : head.oam) << `ST_OAM_BIT)
                        | (32'(ovfl_q) << `ST_OVFL_BIT);
   wire [31:0] rd_mux   = hit_val ? (empty ? 32'h0 : head.stamp) :
                          hit_st  ? status_w :
                          hit_up  ? used_q[63:32] :
                          hit_lo  ? used_q[31:0] :
                          hit_dis ? 32'(dis_q) :
                          hit_cnt ? 32'(`SQ_FREE_IDS - used_cnt) : 32'h0;

   // Queue memory write, no reset needed
   always_ff @(posedge CLK) begin
      if (push) begin
         mem_q[wr_ptr_q] <= new_ent;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_q + `SQ_PTR_W'(push);
         rd_ptr_q <= rd_ptr_q + `SQ_PTR_W'(pop);
         count_q  <= count_q + `SQ_CNT_W'(push) - `SQ_CNT_W'(pop);
      end
   end

   // Overflow flag: sticky, cleared by reading status, set wins
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ovfl_q <= 1'b0;
      end else begin
         // Clear only an overflow that the captured status word reported
         ovfl_q <= drop | (ovfl_q & ~(rd & hit_st & prdata_q[`ST_OVFL_BIT]));
      end
   end

   // Identifier pool: allocation wins over release in same cycle
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         used_q <= `SQ_ID_POOL_INIT;
      end else begin
         used_q <= ((used_q & ~rel_mask) | set_mask) | `SQ_ID_POOL_INIT;
      end
   end

   // Port disable register
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dis_q <= '0;
      end else if (wr & hit_dis) begin
         dis_q <= PWDATA[`SQ_NPORTS-1:0];
      end
   end

   // Allocation answer and extraction header fields
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         alloc_st_q  <= ALLOC_IDLE;
         alloc_id_q  <= '0;
         alloc_two_q <= 1'b0;
         xtr_dscp_q  <= '0;
         xtr_rx_q    <= '0;
         xtr_vld_q   <= 1'b0;
      end else begin
         case (alloc_st_q)
            ALLOC_IDLE: begin
               xtr_vld_q <= 1'b0;
               if (ALLOC_REQ) begin
                  alloc_st_q  <= ALLOC_HELD;
                  alloc_two_q <= two_step_frm;
                  alloc_id_q  <= two_step_frm ? free_id : '0;
                  xtr_dscp_q  <= two_step_frm ? free_id : '0;
                  xtr_rx_q    <= ALLOC_RX_STAMP;
                  xtr_vld_q   <= ALLOC_TO_CPU;
               end
            end
            ALLOC_HELD: begin
               xtr_vld_q  <= 1'b0;
               alloc_st_q <= ALLOC_IDLE;
            end
            default: alloc_st_q <= ALLOC_IDLE;
         endcase
      end
   end

   // APB read data and error
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q  <= (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : prdata_q;
         pslverr_q <= PSEL & ~PENABLE & ~mapped;
      end
   end

   assign PRDATA         = prdata_q;
   assign PREADY         = 1'b1;
   assign PSLVERR        = acc & pslverr_q;
   assign ALLOC_ID       = alloc_id_q;
   assign ALLOC_TWO_STEP = alloc_two_q;
   assign XTR_DSCP       = xtr_dscp_q;
   assign XTR_RX_STAMP   = xtr_rx_q;
   assign XTR_VALID      = xtr_vld_q;

   // Assertions
   // Full queue drops the stamp and flags it
   full_drops_a: assert property (@(posedge CLK) disable iff (RST)
      drop & ~pop |=> ovfl_q & (count_q == `SQ_CNT_W'(`SQ_DEPTH)))
      else $error("stamp on full queue not dropped with overflow");

   // Empty head shows no valid entry
   empty_valid_a: assert property (@(posedge CLK) disable iff (RST)
      empty |-> status_w[`ST_VALID_BIT] == 1'b0)
      else $error("valid set while queue empty");

   // Queued head shows valid
   valid_ready_a: assert property (@(posedge CLK) disable iff (RST)
      ~empty |-> status_w[`ST_VALID_BIT] == 1'b1)
      else $error("valid clear while entry queued");

   // Advance removes one entry
   pop_moves_a: assert property (@(posedge CLK) disable iff (RST)
      pop & ~push |=> count_q == $past(count_q) - 1'b1)
      else $error("advance did not pop head");

   // Advance on empty queue leaves it untouched
   empty_adv_a: assert property (@(posedge CLK) disable iff (RST)
      empty & wr & hit_adv & ~push |=> empty & (rd_ptr_q == $past(rd_ptr_q)))
      else $error("advance on empty queue changed state");

   // Occupancy never passes the depth
   depth_bound_a: assert property (@(posedge CLK) disable iff (RST)
      count_q <= `SQ_CNT_W'(`SQ_DEPTH))
      else $error("occupancy above depth");

   // Accepted stamp grows occupancy
   push_count_a: assert property (@(posedge CLK) disable iff (RST)
      push & ~pop |=> count_q == $past(count_q) + 1'b1)
      else $error("push did not grow occupancy");

   // Stored entry keeps the port, id and time seen
   push_store_a: assert property (@(posedge CLK) disable iff (RST)
      push |=> mem_q[$past(wr_ptr_q)] == $past(new_ent))
      else $error("stamp entry not stored as seen");

   // Two-step entries never carry the OAM mark
   head_oam_a: assert property (@(posedge CLK) disable iff (RST)
      ~empty |-> head.oam == 1'b0)
      else $error("two-step entry marked as OAM");

   // Status fields show the head entry
   head_fields_a: assert property (@(posedge CLK) disable iff (RST)
      ~empty |-> (status_w[`ST_ID_LSB +: `SQ_ID_W] == head.id)
                 & (status_w[`ST_PORT_LSB +: `SQ_PORT_W] == head.port))
      else $error("status fields differ from head");

   // Value register shows the head stamp
   head_stamp_a: assert property (@(posedge CLK) disable iff (RST)
      ~empty & hit_val |-> rd_mux == head.stamp)
      else $error("value register differs from head");

   // Read side moves one slot per pop
   pop_order_a: assert property (@(posedge CLK) disable iff (RST)
      pop & ~push |=> rd_ptr_q == $past(rd_ptr_q) + 1'b1)
      else $error("read pointer skipped an entry");

   // Overflow sticks until a status read
   ovfl_hold_a: assert property (@(posedge CLK) disable iff (RST)
      ovfl_q & ~(rd & hit_st) |=> ovfl_q)
      else $error("overflow lost without status read");

   // Reserved identifiers never handed out
   reserved_ids_a: assert property (@(posedge CLK) disable iff (RST)
      alloc_two_q |-> alloc_id_q >= `SQ_ID_FIRST_FREE)
      else $error("reserved identifier allocated");

   // Reserved identifiers always stay marked
   reserved_kept_a: assert property (@(posedge CLK) disable iff (RST)
      (used_q & `SQ_ID_POOL_INIT) == `SQ_ID_POOL_INIT)
      else $error("reserved identifier freed");

   // Released identifiers return to the pool
   rel_frees_a: assert property (@(posedge CLK) disable iff (RST)
      (rel_mask != '0) & ~grant |=> (used_q & $past(rel_mask) & ~`SQ_ID_POOL_INIT) == '0)
      else $error("released identifier still in use");

   // Exhausted pool answers with the untrusted id
   exhaust_id_a: assert property (@(posedge CLK) disable iff (RST)
      two_step_frm & (alloc_st_q == ALLOC_IDLE) & ~free_found
      |=> alloc_id_q == `SQ_ID_UNTRUSTED)
      else $error("exhausted pool did not give 63");

   // Untrusted id only when every free id is taken
   last_resort_a: assert property (@(posedge CLK) disable iff (RST)
      ~free_found |-> &used_q[`SQ_ID_HI_ALLOC:`SQ_ID_LO_ALLOC])
      else $error("untrusted id while a free id exists");

   // Disabled port stamps never enter the queue
   disabled_port_a: assert property (@(posedge CLK) disable iff (RST)
      TX_STAMP_VLD & port_dis |-> ~push)
      else $error("disabled port pushed a stamp");

   // CPU-bound frames never enter the queue
   cpu_frame_a: assert property (@(posedge CLK) disable iff (RST)
      TX_STAMP_VLD & TX_TO_CPU |-> ~push)
      else $error("CPU-bound frame queued");

   // Allocated id was free beforehand
   fresh_id_a: assert property (@(posedge CLK) disable iff (RST)
      grant & (alloc_st_q == ALLOC_IDLE) |=> $past(used_q[free_id]) == 1'b0)
      else $error("identifier allocated while in use");

   // Refused request claims no identifier
   held_refuse_a: assert property (@(posedge CLK) disable iff (RST)
      alloc_st_q == ALLOC_HELD |-> set_mask == '0)
      else $error("refused request claimed an identifier");

   // Two-step answer follows the rewrite action
   two_step_flag_a: assert property (@(posedge CLK) disable iff (RST)
      ALLOC_REQ & (alloc_st_q == ALLOC_IDLE)
      |=> alloc_two_q == ($past(ALLOC_ACTION) == `SQ_ACT_TWO_STEP))
      else $error("two-step answer wrong for action");

   // Header carries the identifier in the DSCP slot
   xtr_dscp_a: assert property (@(posedge CLK) disable iff (RST)
      alloc_two_q |-> xtr_dscp_q == alloc_id_q)
      else $error("header DSCP slot differs from id");

   // Header carries the frame's receive stamp
   xtr_rx_a: assert property (@(posedge CLK) disable iff (RST)
      ALLOC_REQ & (alloc_st_q == ALLOC_IDLE) |=> xtr_rx_q == $past(ALLOC_RX_STAMP))
      else $error("header receive stamp wrong");

   // Header valid lasts one cycle
   xtr_pulse_a: assert property (@(posedge CLK) disable iff (RST)
      xtr_vld_q |=> ~xtr_vld_q)
      else $error("header valid held too long");

endmodule // two_step_timestamp_queue

// ==== two_step_timestamp_queue_bench.sv ====
// Self-checking bench for the two-step stamp queue: random stamps, corner cases.
// Assumes the design, its package and the software model are compiled first.
`timescale 1ns/1ps
`include "stamp_queue_consts.svh"
module two_step_timestamp_queue_bench
   import stamp_queue_pkg::*;
;
   logic CLK = 1'b0, RST = 1'b1, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, ALLOC_REQ = 1'b0;
   logic ALLOC_TO_CPU = 1'b0, ALLOC_TWO_STEP, XTR_VALID, TX_STAMP_VLD = 1'b0;
   logic TX_TWO_STEP = 1'b0, TX_TO_CPU = 1'b0;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, TX_STAMP = 32'h0, rd;
   logic [2:0]  ALLOC_ACTION = 3'h0, act;
   logic [47:0] ALLOC_RX_STAMP = 48'h0, XTR_RX_STAMP;
   logic [5:0]  ALLOC_ID, XTR_DSCP, TX_ID = 6'h00, id_a, id_b, last_id;
   logic [3:0]  TX_PORT = 4'h0;
   logic [63:0] used;
   logic [10:0] dis;
   logic        er, ovfl;
   int          errors, check_count;
   stamp_entry_t exp_q[$];

   // Clock, 25 ns period
   always #12.5 CLK = ~CLK;

   two_step_timestamp_queue dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .ALLOC_REQ(ALLOC_REQ), .ALLOC_ACTION(ALLOC_ACTION),
      .ALLOC_TO_CPU(ALLOC_TO_CPU), .ALLOC_RX_STAMP(ALLOC_RX_STAMP),
      .ALLOC_TWO_STEP(ALLOC_TWO_STEP), .ALLOC_ID(ALLOC_ID), .XTR_DSCP(XTR_DSCP),
      .XTR_RX_STAMP(XTR_RX_STAMP), .XTR_VALID(XTR_VALID), .TX_STAMP_VLD(TX_STAMP_VLD),
      .TX_STAMP(TX_STAMP), .TX_PORT(TX_PORT), .TX_ID(TX_ID), .TX_TWO_STEP(TX_TWO_STEP),
      .TX_TO_CPU(TX_TO_CPU));
   cpu_sw_model sw_u (.CLK(CLK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

   // Verdict and end of run
   task end_of_test();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Compare one register or port value
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Lowest free identifier above the reserved ones, else the untrusted value
   function automatic logic [5:0] next_id(input logic [63:0] u);
      for (int i = 4; i < 63; i++) if (!u[i]) return 6'(i);
      return 6'h3f;
   endfunction

   // Bus transfer through the software model; a lost handshake ends the run
   task rw(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic ok;
      sw_u.xfer(w, a, d, rd, er, ok);
      if (ok !== 1'b1) begin
         errors++;
         $display("ERROR apb_ready expected 1 seen %b", ok);
         end_of_test();
      end
   endtask

   // Release an identifier, then check the free count
   task rel(input logic [5:0] id);
      logic ok;
      sw_u.release_id(id, ok);
      used[id] = 1'b0;
      rw(1'b0, `OFS_FREE_COUNT, 32'h0);
      chk("free_count", 32'(59 - $countones(used[62:4])), rd);
   endtask

   // One classified frame asking for an identifier
   task alloc(input logic [2:0] a, input logic cpu);
      logic [47:0] rx;
      logic [5:0]  e;
      rx = {16'($urandom), $urandom};
      e = next_id(used);
      @(posedge CLK);
      ALLOC_REQ <= 1'b1;
      ALLOC_ACTION <= a;
      ALLOC_TO_CPU <= cpu;
      ALLOC_RX_STAMP <= rx;
      @(posedge CLK);
      ALLOC_REQ <= 1'b0;
      #1;
      chk("two_step", {31'h0, a == `SQ_ACT_TWO_STEP}, {31'h0, ALLOC_TWO_STEP});
      chk("xtr_valid", {31'h0, cpu}, {31'h0, XTR_VALID});
      if (cpu) chk("xtr_rx", rx[47:16], XTR_RX_STAMP[47:16]);
      if (cpu) chk("xtr_rx_lo", 32'(rx[15:0]), 32'(XTR_RX_STAMP[15:0]));
      if (a == `SQ_ACT_TWO_STEP) begin
         chk("alloc_id", {26'h0, e}, {26'h0, ALLOC_ID});
         if (cpu) chk("xtr_dscp", {26'h0, e}, {26'h0, XTR_DSCP});
         if (e != 6'h3f) used[e] = 1'b1;
         last_id = e;
      end
   endtask

   // One egress stamp event and its expected queue effect
   task stamp(input logic [3:0] p, input logic [5:0] id, input logic cpu, input logic two);
      stamp_entry_t x;
      x.oam = 1'b0;
      x.port = p;
      x.id = id;
      x.stamp = $urandom;
      @(posedge CLK);
      TX_STAMP_VLD <= 1'b1;
      TX_STAMP <= x.stamp;
      TX_PORT <= p;
      TX_ID <= id;
      TX_TWO_STEP <= two;
      TX_TO_CPU <= cpu;
      @(posedge CLK);
      TX_STAMP_VLD <= 1'b0;
      TX_STAMP <= ~x.stamp;
      if (two && !cpu && !dis[p]) begin
         if (exp_q.size() < `SQ_DEPTH) exp_q.push_back(x);
         else ovfl = 1'b1;
      end
   endtask

   // Read and check the head entry, then pop it
   task pop_one();
      stamp_entry_t x;
      x = exp_q.pop_front();
      rw(1'b0, `OFS_HEAD_STATUS, 32'h0);
      chk("status", {19'h0, ovfl, x.oam, x.port, x.id, 1'b1}, rd & 32'h1fff);
      ovfl = 1'b0;
      rw(1'b0, `OFS_HEAD_VALUE, 32'h0);
      chk("stamp", x.stamp, rd);
      rw(1'b1, `OFS_ADVANCE, $urandom);
   endtask

   // Hang guard
   initial begin
      repeat (90000) @(posedge CLK);
      errors++;
      $display("ERROR watchdog expected done seen timeout");
      end_of_test();
   end

   // Main sequence
   initial begin
      errors = 0;
      check_count = 0;
      used = 64'hf;
      dis = 11'h0;
      ovfl = 1'b0;
      void'($urandom(32'h5039));
      repeat (6) @(posedge CLK);
      RST <= 1'b0;
      rw(1'b0, `OFS_HEAD_STATUS, 32'h0);
      chk("status_reset", 32'h0, rd & 32'h1fff);
      rw(1'b0, `OFS_REL_LOWER, 32'h0);
      chk("used_low", 32'h0000000f, rd);
      rw(1'b0, 12'h01c, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      chk("unmapped_rd", 32'h0, rd);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         act = 3'($urandom_range(0, 6));
         alloc(act >= 3'h3 ? act + 3'h1 : act, 1'b0);
      end
      alloc(`SQ_ACT_TWO_STEP, 1'b1);
      id_b = last_id;
      alloc(`SQ_ACT_TWO_STEP, 1'b0);
      id_a = last_id;
      $display("test allocate done");
      dis = 11'h004;
      rw(1'b1, `OFS_TWO_STEP_DIS, 32'h4);
      rw(1'b0, `OFS_TWO_STEP_DIS, 32'h0);
      chk("port_dis", 32'(dis), rd);
      foreach (dis[p]) if (p % 5 == 0) stamp(4'(p), id_a, 1'b0, 1'b1);
      stamp(4'h3, id_b, 1'b1, 1'b1);
      stamp(4'h4, id_a, 1'b0, 1'b0);
      stamp(4'h2, id_a, 1'b0, 1'b1);
      while (exp_q.size() > 0) pop_one();
      rw(1'b1, `OFS_ADVANCE, 32'h0);
      rw(1'b0, `OFS_HEAD_STATUS, 32'h0);
      chk("empty_advance", 32'h0, rd & 32'h1fff);
      rel(id_a);
      rel(id_b);
      $display("test multicast done");
      dis = 11'h0;
      rw(1'b1, `OFS_TWO_STEP_DIS, 32'h0);
      repeat (`SQ_DEPTH + 1) stamp(4'($urandom_range(0, 10)), id_a, 1'b0, 1'b1);
      while (exp_q.size() > 0) pop_one();
      rw(1'b0, `OFS_HEAD_STATUS, 32'h0);
      chk("drained", 32'h0, rd & 32'h1fff);
      $display("test overflow done");
      repeat (60) alloc(`SQ_ACT_TWO_STEP, 1'b0);
      rw(1'b0, `OFS_REL_UPPER, 32'h0);
      chk("used_high", used[63:32], rd);
      rel(6'd10);
      rel(6'd40);
      alloc(`SQ_ACT_TWO_STEP, 1'b0);
      alloc(`SQ_ACT_TWO_STEP, 1'b0);
      $display("test exhaust done");
      end_of_test();
   end
endmodule // two_step_timestamp_queue_bench
